/* File: hdl/fpb_pkg.sv */
// Shared constants and carrier types for the FIFO1 port B flag block.
package fpb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 36;
  localparam int ADDR_W = 8;
  localparam int REG_W = 32;
  localparam int OFFSET_W = 10;
  localparam int CNT_W = 12;
  localparam int STATUS_W = 6;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_AE_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] REG_AF_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_FILL = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_FTM_BIT = 0;
  localparam logic CTRL_FTM_RESET = 1'b0;
  localparam logic [OFFSET_W-1:0] AE_OFFSET_RESET = 10'h008;
  localparam logic [OFFSET_W-1:0] AF_OFFSET_RESET = 10'h008;
  localparam logic [REG_W-1:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic select_n;
    logic dir;
    logic enable;
    logic mail_select;
  } fpb_portb_s;

  typedef struct packed {
    logic almost_full_n;
    logic full_or_ready;
    logic almost_empty_n;
    logic empty_or_ready;
    logic mail_to_a_full_n;
    logic mail_to_b_full_n;
  } fpb_status_s;

endpackage

/* File: hdl/fpb_mem.sv */
// FIFO1 storage array with one write port and one unregistered read port.
`timescale 1ns/1ps

module fpb_mem
#(
  parameter int DEPTH = 256,
  parameter int AW = 8
)
(
  // Clock
  input wire logic i_clk,
  // Write side
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [fpb_pkg::DATA_W-1:0] i_wdata,
  // Read side
  input wire logic [AW-1:0] i_raddr,
  output logic [fpb_pkg::DATA_W-1:0] o_rdata
);

  logic [fpb_pkg::DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // The read is combinational so a word moves to the output register on the same port edge.
  assign o_rdata = mem[i_raddr];

endmodule

/* File: hdl/fpb_fifo1_flags_port_b.sv */
// FIFO1 port B decode, output register, mailboxes and read/write side flags.
`timescale 1ns/1ps

module fpb_fifo1_flags_port_b
#(
  parameter int DEPTH = 256
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [fpb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [fpb_pkg::REG_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [fpb_pkg::REG_W-1:0] o_rdata,
  // Port A side (qualified requests, taken on a rising port A clock)
  input wire logic i_port_a_clock,
  input wire logic i_a_fifo_write,
  input wire logic i_a_mail_write,
  input wire logic i_a_mail2_read,
  input wire logic [fpb_pkg::DATA_W-1:0] i_a_data,
  output logic o_fifo1_full_or_ready,
  output logic o_fifo1_almost_full_n,
  output logic [fpb_pkg::DATA_W-1:0] o_mail2_data,
  // Port B pins
  input wire logic i_port_b_clock,
  input wire fpb_pkg::fpb_portb_s i_port_b_ctrl,
  input wire logic [fpb_pkg::DATA_W-1:0] i_port_b_data_bus,
  output logic [fpb_pkg::DATA_W-1:0] o_port_b_data_bus,
  output logic o_port_b_data_bus_oe_n,
  output logic o_fifo1_empty_or_ready,
  output logic o_fifo1_almost_empty_n,
  output logic o_mail_to_b_full_n,
  output logic o_mail_to_a_full_n,
  // FIFO2 write hand-off
  output logic o_fifo2_write,
  output logic [fpb_pkg::DATA_W-1:0] o_fifo2_data
);

  // ----------------------------------------------------------------
  // Derived sizes
  // ----------------------------------------------------------------
  // DEPTH is meant to be 256, 512 or 1024; the full and almost-full thresholds below derive from it, almost-empty uses ae_offset alone.
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [fpb_pkg::CNT_W-1:0] DEPTH_CNT = fpb_pkg::CNT_W'(DEPTH);

  // Fill count between two wrap-marked pointers.
  function automatic logic [fpb_pkg::CNT_W-1:0] fill(input logic [PW-1:0] wp, input logic [PW-1:0] rp);
    logic [PW-1:0] diff;
    diff = wp - rp;
    return fpb_pkg::CNT_W'(diff);
  endfunction

  // Pointer advanced by zero or one.
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p, input logic step);
    return p + {{(PW-1){1'b0}}, step};
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ctrl_ftm;
  logic [fpb_pkg::OFFSET_W-1:0] ae_offset;
  logic [fpb_pkg::OFFSET_W-1:0] af_offset;
  logic a_clk_q;
  logic b_clk_q;
  logic a_edge;
  logic b_edge;
  logic b_op;
  logic b_fifo_read;
  logic b_mail1_read;
  logic b_fifo2_write;
  logic b_mail2_write;
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [PW-1:0] wptr_sync1;
  logic [PW-1:0] wptr_sync2;
  logic [PW-1:0] rptr_sync;
  logic [PW-1:0] next_wptr;
  logic [PW-1:0] next_rptr;
  logic a_write_ok;
  logic read_ok;
  logic move;
  logic [fpb_pkg::CNT_W-1:0] fill_b;
  logic [fpb_pkg::CNT_W-1:0] fill_a;
  logic [fpb_pkg::CNT_W-1:0] af_limit;
  logic [fpb_pkg::DATA_W-1:0] mem_rdata;
  logic [fpb_pkg::DATA_W-1:0] mail1;
  fpb_pkg::fpb_status_s status;

  // ----------------------------------------------------------------
  // Port clock edges
  // ----------------------------------------------------------------
  // Port clocks arrive synchronous to i_clk, so a one-cycle delay suffices to find their rising edges.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      a_clk_q <= 1'b0;
      b_clk_q <= 1'b0;
    end
    else
    begin
      a_clk_q <= i_port_a_clock;
      b_clk_q <= i_port_b_clock;
    end
  end

  assign a_edge = i_port_a_clock & ~a_clk_q;
  assign b_edge = i_port_b_clock & ~b_clk_q;

  // ----------------------------------------------------------------
  // Port B decode
  // ----------------------------------------------------------------
  assign b_op = b_edge & ~i_port_b_ctrl.select_n & i_port_b_ctrl.enable;
  assign b_fifo_read = b_op & i_port_b_ctrl.dir & ~i_port_b_ctrl.mail_select;
  assign b_mail1_read = b_op & i_port_b_ctrl.dir & i_port_b_ctrl.mail_select;
  assign b_fifo2_write = b_op & ~i_port_b_ctrl.dir & ~i_port_b_ctrl.mail_select;
  assign b_mail2_write = b_op & ~i_port_b_ctrl.dir & i_port_b_ctrl.mail_select;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  assign a_write_ok = a_edge & i_a_fifo_write & o_fifo1_full_or_ready;

  fpb_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .i_clk(i_clk),
    .i_we(a_write_ok),
    .i_waddr(wptr[AW-1:0]),
    .i_wdata(i_a_data),
    .i_raddr(rptr[AW-1:0]),
    .o_rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Read side (port B clock)
  // ----------------------------------------------------------------
  // A read only counts while the dual-purpose flag is high.
  assign read_ok = b_fifo_read & o_fifo1_empty_or_ready;

  // Fall-through loads from the second sync stage, giving the third edge; standard loads on request.
  always_comb
  begin
    if (ctrl_ftm)
    begin
      move = b_edge & (wptr_sync2 != rptr) & (~o_fifo1_empty_or_ready | read_ok);
    end
    else
    begin
      move = read_ok;
    end
  end

  assign next_rptr = bump(rptr, move);
  assign fill_b = fill(wptr_sync1, next_rptr);

  // A write landing in the same i_clk cycle as a B edge is captured only on the next B edge.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      wptr_sync1 <= '0;
      wptr_sync2 <= '0;
    end
    else if (b_edge)
    begin
      wptr_sync1 <= wptr;
      wptr_sync2 <= wptr_sync1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      rptr <= '0;
    end
    else
    begin
      rptr <= next_rptr;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_fifo1_empty_or_ready <= 1'b0;
    end
    else if (b_edge)
    begin
      if (ctrl_ftm)
      begin
        if (move)
        begin
          o_fifo1_empty_or_ready <= 1'b1;
        end
        else if (read_ok)
        begin
          o_fifo1_empty_or_ready <= 1'b0;
        end
      end
      else
      begin
        o_fifo1_empty_or_ready <= (wptr_sync1 != next_rptr);
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_fifo1_almost_empty_n <= 1'b0;
    end
    else if (b_edge)
    begin
      o_fifo1_almost_empty_n <= (fill_b > fpb_pkg::CNT_W'(ae_offset));
    end
  end

  // The output register only changes on a move or a mail read, so a refused read keeps the old word.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_port_b_data_bus <= '0;
    end
    else if (move)
    begin
      o_port_b_data_bus <= mem_rdata;
    end
    else if (b_mail1_read)
    begin
      o_port_b_data_bus <= mail1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_port_b_data_bus_oe_n <= 1'b1;
    end
    else
    begin
      o_port_b_data_bus_oe_n <= ~(~i_port_b_ctrl.select_n & i_port_b_ctrl.dir);
    end
  end

  // ----------------------------------------------------------------
  // Write side (port A clock)
  // ----------------------------------------------------------------
  assign next_wptr = bump(wptr, a_write_ok);
  assign fill_a = fill(next_wptr, rptr_sync);
  assign af_limit = DEPTH_CNT - fpb_pkg::CNT_W'(af_offset);

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      wptr <= '0;
    end
    else
    begin
      wptr <= next_wptr;
    end
  end

  // A freed location becomes writable on the second A edge after the move.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      rptr_sync <= '0;
    end
    else if (a_edge)
    begin
      rptr_sync <= rptr;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_fifo1_full_or_ready <= 1'b0;
      o_fifo1_almost_full_n <= 1'b1;
    end
    else if (a_edge)
    begin
      o_fifo1_full_or_ready <= (fill_a < DEPTH_CNT);
      o_fifo1_almost_full_n <= (fill_a < af_limit);
    end
  end

  // ----------------------------------------------------------------
  // Mailboxes
  // ----------------------------------------------------------------
  // A write that finds the flag high wins over a read in the same cycle.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_mail_to_b_full_n <= 1'b1;
      mail1 <= '0;
    end
    else if (a_edge & i_a_mail_write & o_mail_to_b_full_n)
    begin
      o_mail_to_b_full_n <= 1'b0;
      mail1 <= i_a_data;
    end
    else if (b_mail1_read)
    begin
      o_mail_to_b_full_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_mail_to_a_full_n <= 1'b1;
      o_mail2_data <= '0;
    end
    else if (b_mail2_write & o_mail_to_a_full_n)
    begin
      o_mail_to_a_full_n <= 1'b0;
      o_mail2_data <= i_port_b_data_bus;
    end
    else if (a_edge & i_a_mail2_read)
    begin
      o_mail_to_a_full_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_fifo2_write <= 1'b0;
      o_fifo2_data <= '0;
    end
    else
    begin
      o_fifo2_write <= b_fifo2_write;
      if (b_fifo2_write)
      begin
        o_fifo2_data <= i_port_b_data_bus;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      ctrl_ftm <= fpb_pkg::CTRL_FTM_RESET;
      ae_offset <= fpb_pkg::AE_OFFSET_RESET;
      af_offset <= fpb_pkg::AF_OFFSET_RESET;
    end
    else if (i_wr)
    begin
      case (i_addr)
        fpb_pkg::REG_CTRL: ctrl_ftm <= i_wdata[fpb_pkg::CTRL_FTM_BIT];
        fpb_pkg::REG_AE_OFFSET: ae_offset <= i_wdata[fpb_pkg::OFFSET_W-1:0];
        fpb_pkg::REG_AF_OFFSET: af_offset <= i_wdata[fpb_pkg::OFFSET_W-1:0];
        default: ;
      endcase
    end
  end

  assign status = '{
    almost_full_n: o_fifo1_almost_full_n,
    full_or_ready: o_fifo1_full_or_ready,
    almost_empty_n: o_fifo1_almost_empty_n,
    empty_or_ready: o_fifo1_empty_or_ready,
    mail_to_a_full_n: o_mail_to_a_full_n,
    mail_to_b_full_n: o_mail_to_b_full_n
  };

  // Read data stands for exactly one cycle; unmapped addresses read zero.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_rdata <= fpb_pkg::READ_ZERO;
    end
    else if (i_rd)
    begin
      case (i_addr)
        fpb_pkg::REG_CTRL: o_rdata <= fpb_pkg::REG_W'(ctrl_ftm);
        fpb_pkg::REG_AE_OFFSET: o_rdata <= fpb_pkg::REG_W'(ae_offset);
        fpb_pkg::REG_AF_OFFSET: o_rdata <= fpb_pkg::REG_W'(af_offset);
        fpb_pkg::REG_STATUS: o_rdata <= fpb_pkg::REG_W'(status);
        fpb_pkg::REG_FILL: o_rdata <= fpb_pkg::REG_W'(fill(wptr_sync1, rptr));
        default: o_rdata <= fpb_pkg::READ_ZERO;
      endcase
    end
    else
    begin
      o_rdata <= fpb_pkg::READ_ZERO;
    end
  end

endmodule

/* File: tb/fpb_flags_assertions.sv */
// Concurrent checks on the ports of the FIFO1 port B flag block.
`timescale 1ns/1ps

module fpb_flags_assertions
#(
  parameter int DEPTH = 256
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Port inputs
  input wire logic i_port_a_clock,
  input wire logic i_a_mail_write,
  input wire logic i_port_b_clock,
  input wire fpb_pkg::fpb_portb_s i_port_b_ctrl,
  // Design outputs
  input wire logic [fpb_pkg::DATA_W-1:0] o_port_b_data_bus,
  input wire logic o_port_b_data_bus_oe_n,
  input wire logic o_fifo1_empty_or_ready,
  input wire logic o_fifo1_almost_empty_n,
  input wire logic o_fifo1_full_or_ready,
  input wire logic o_fifo1_almost_full_n,
  input wire logic o_mail_to_b_full_n,
  input wire logic o_fifo2_write
);
  logic a_prev;
  logic b_prev;
  logic a_edge;
  logic b_edge;
  logic rd_sel;
  logic b_op;

  always_ff @(posedge i_clk) a_prev <= i_resetn ? i_port_a_clock : 1'b0;
  always_ff @(posedge i_clk) b_prev <= i_resetn ? i_port_b_clock : 1'b0;
  assign a_edge = i_port_a_clock && !a_prev;
  assign b_edge = i_port_b_clock && !b_prev;
  assign rd_sel = !i_port_b_ctrl.select_n && i_port_b_ctrl.dir;
  assign b_op = b_edge && !i_port_b_ctrl.select_n && i_port_b_ctrl.enable;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_oe_follows: assert property (1'b1 |=> o_port_b_data_bus_oe_n == !$past(rd_sel))
    else $error("bus enable does not follow select and direction");
  chk_mail1_empty: assert property (b_op && i_port_b_ctrl.dir && i_port_b_ctrl.mail_select
    |-> ##[1:2] o_mail_to_b_full_n) else $error("mail1 flag not raised by read");
  chk_mail1_fill: assert property (a_edge && i_a_mail_write && o_mail_to_b_full_n
    |-> ##[1:2] !o_mail_to_b_full_n) else $error("mail1 flag not lowered by write");
  chk_data_on_b: assert property ($changed(o_port_b_data_bus) |-> $past(b_edge) || $past(b_edge, 2))
    else $error("output word moved without a port B edge");
  chk_eor_on_b: assert property ($changed(o_fifo1_empty_or_ready) |-> $past(b_edge) || $past(b_edge, 2))
    else $error("read flag moved without a port B edge");
  chk_ae_on_b: assert property ($changed(o_fifo1_almost_empty_n) |-> $past(b_edge) || $past(b_edge, 2))
    else $error("almost empty moved without a port B edge");
  chk_ir_on_a: assert property ($changed(o_fifo1_full_or_ready) |-> $past(a_edge) || $past(a_edge, 2))
    else $error("write flag moved without a port A edge");
  chk_af_on_a: assert property ($changed(o_fifo1_almost_full_n) |-> $past(a_edge) || $past(a_edge, 2))
    else $error("almost full moved without a port A edge");
  chk_f2_write: assert property (b_op && !i_port_b_ctrl.dir && !i_port_b_ctrl.mail_select
    |-> ##[1:2] o_fifo2_write) else $error("FIFO2 write not handed off");
  chk_f2_pulse: assert property (o_fifo2_write |=> !o_fifo2_write)
    else $error("FIFO2 write pulse longer than one cycle");
endmodule

bind fpb_fifo1_flags_port_b fpb_flags_assertions #(.DEPTH(DEPTH)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_port_a_clock(i_port_a_clock), .i_a_mail_write(i_a_mail_write), .i_port_b_clock(i_port_b_clock),
  .i_port_b_ctrl(i_port_b_ctrl), .o_port_b_data_bus(o_port_b_data_bus),
  .o_port_b_data_bus_oe_n(o_port_b_data_bus_oe_n), .o_fifo1_empty_or_ready(o_fifo1_empty_or_ready),
  .o_fifo1_almost_empty_n(o_fifo1_almost_empty_n), .o_fifo1_full_or_ready(o_fifo1_full_or_ready),
  .o_fifo1_almost_full_n(o_fifo1_almost_full_n), .o_mail_to_b_full_n(o_mail_to_b_full_n),
  .o_fifo2_write(o_fifo2_write));

/* File: tb/fpb_port_a_model.sv */
// Port A side model: makes one port A clock edge per request.
`timescale 1ns/1ps

module fpb_port_a_model
(
  // Clock
  input wire logic i_clk,
  // Port A requests
  output logic o_port_a_clock,
  output logic o_fifo_write,
  output logic o_mail_write,
  output logic o_mail2_read,
  output logic [fpb_pkg::DATA_W-1:0] o_data
);
  initial
  begin
    o_port_a_clock = 1'b0;
    o_fifo_write = 1'b0;
    o_mail_write = 1'b0;
    o_mail2_read = 1'b0;
    o_data = 36'h0_0000_0000;
  end

  // Kind 0 is an idle edge, 1 a FIFO1 write, 2 a mail1 write, 3 a mail2 read.
  task automatic pulse(input logic [1:0] kind, input logic [fpb_pkg::DATA_W-1:0] d);
    @(posedge i_clk);
    o_fifo_write <= (kind == 2'h1);
    o_mail_write <= (kind == 2'h2);
    o_mail2_read <= (kind == 2'h3);
    o_data <= d;
    o_port_a_clock <= 1'b1;
    @(posedge i_clk);
    o_port_a_clock <= 1'b0;
    o_fifo_write <= 1'b0;
    o_mail_write <= 1'b0;
    o_mail2_read <= 1'b0;
    // Released data shows the inverse so a stale word is never mistaken for a held one.
    o_data <= ~d;
    @(posedge i_clk);
    #1;
  endtask
endmodule

/* File: tb/tb_fifo1_flags_port_b.sv */
// Self-checking bench for the FIFO1 port B flag block.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_fifo1_flags_port_b;
  localparam int DEPTH = 256;
  localparam logic [3:0] RD = 4'h6;
  localparam logic [3:0] MB1 = 4'h7;
  localparam logic [3:0] F2 = 4'h2;
  localparam logic [3:0] MB2 = 4'h3;
  localparam logic [3:0] IDLE = 4'h4;
  logic i_clk;
  logic i_resetn;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  wire logic pa_clk, pa_fw, pa_mw, pa_mr;
  wire logic [35:0] pa_data;
  logic i_port_b_clock;
  fpb_pkg::fpb_portb_s i_port_b_ctrl;
  logic [35:0] i_port_b_data_bus, o_port_b_data_bus, o_mail2_data, o_fifo2_data;
  logic oe_n, eor, ae_n, fr, af_n, mtb, mta, f2w;
  int error_cnt = 0;
  int checks_done = 0;
  int f2_cnt = 0;
  int cyc = 0;

  fpb_port_a_model pa (.i_clk(i_clk), .o_port_a_clock(pa_clk), .o_fifo_write(pa_fw), .o_mail_write(pa_mw),
    .o_mail2_read(pa_mr), .o_data(pa_data));
  fpb_fifo1_flags_port_b #(.DEPTH(DEPTH)) uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_a_clock(pa_clk),
    .i_a_fifo_write(pa_fw), .i_a_mail_write(pa_mw), .i_a_mail2_read(pa_mr), .i_a_data(pa_data),
    .o_fifo1_full_or_ready(fr), .o_fifo1_almost_full_n(af_n), .o_mail2_data(o_mail2_data),
    .i_port_b_clock(i_port_b_clock), .i_port_b_ctrl(i_port_b_ctrl), .i_port_b_data_bus(i_port_b_data_bus),
    .o_port_b_data_bus(o_port_b_data_bus), .o_port_b_data_bus_oe_n(oe_n), .o_fifo1_empty_or_ready(eor),
    .o_fifo1_almost_empty_n(ae_n), .o_mail_to_b_full_n(mtb), .o_mail_to_a_full_n(mta),
    .o_fifo2_write(f2w), .o_fifo2_data(o_fifo2_data));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cyc++;
    if (f2w === 1'b1) f2_cnt++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rst();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask

  // One port B edge; the control word goes back to deselected once the edge is taken.
  task automatic b_op(input logic [3:0] c, input logic [35:0] d);
    @(posedge i_clk);
    i_port_b_ctrl <= fpb_pkg::fpb_portb_s'(c);
    i_port_b_data_bus <= d;
    i_port_b_clock <= 1'b1;
    @(posedge i_clk);
    i_port_b_clock <= 1'b0;
    i_port_b_ctrl <= fpb_pkg::fpb_portb_s'(4'h8);
    i_port_b_data_bus <= ~d;
    @(posedge i_clk);
    #1;
  endtask

  task automatic b_sync(input int n);
    repeat (n) b_op(IDLE, 36'h0_0000_0000);
  endtask

  task automatic a_idle(input int n);
    repeat (n) pa.pulse(2'h0, 36'h0_0000_0000);
  endtask

  task automatic wr_words(input int first, input int n);
    for (int k = 0; k < n; k++) pa.pulse(2'h1, 36'h0_0000_1000 + 36'(first + k));
  endtask

  initial
  begin
    i_resetn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_port_b_clock = 1'b0;
    i_port_b_ctrl = fpb_pkg::fpb_portb_s'(4'h8);
    i_port_b_data_bus = 36'h0_0000_0000;
    rst();
    a_idle(2);
    reg_chk(fpb_pkg::REG_STATUS, 32'h0000_0033);
    reg_chk(fpb_pkg::REG_AE_OFFSET, 32'h0000_0008);
    reg_chk(8'h20, 32'h0000_0000);
    wr_words(0, 1);
    b_op(RD, 36'h0_0000_0000);
    `CHK({eor, o_port_b_data_bus}, {1'b0, 36'h0_0000_0000})
    b_op(RD, 36'h0_0000_0000);
    `CHK({eor, o_port_b_data_bus}, {1'b1, 36'h0_0000_0000})
    b_op(RD, 36'h0_0000_0000);
    `CHK({eor, o_port_b_data_bus}, {1'b0, 36'h0_0000_1000})
    reg_chk(fpb_pkg::REG_FILL, 32'h0000_0000);
    rst();
    reg_wr(fpb_pkg::REG_CTRL, 32'h0000_0001);
    a_idle(2);
    wr_words(1, 1);
    b_sync(2);
    `CHK({eor, o_port_b_data_bus}, {1'b0, 36'h0_0000_0000})
    b_sync(1);
    `CHK({eor, o_port_b_data_bus}, {1'b1, 36'h0_0000_1001})
    reg_chk(fpb_pkg::REG_FILL, 32'h0000_0000);
    b_op(RD, 36'h0_0000_0000);
    `CHK({eor, o_port_b_data_bus}, {1'b0, 36'h0_0000_1001})
    rst();
    reg_wr(fpb_pkg::REG_AE_OFFSET, 32'h0000_0002);
    a_idle(2);
    wr_words(0, 2);
    b_sync(3);
    `CHK({eor, ae_n}, 2'b10)
    wr_words(2, 1);
    b_sync(3);
    `CHK(ae_n, 1'b1)
    wr_words(3, DEPTH - 12);
    a_idle(3);
    `CHK({fr, af_n}, 2'b11)
    wr_words(DEPTH - 9, 1);
    a_idle(3);
    `CHK({fr, af_n}, 2'b10)
    wr_words(DEPTH - 8, 8);
    a_idle(3);
    `CHK(fr, 1'b0)
    wr_words(DEPTH, 1);
    b_sync(3);
    reg_chk(fpb_pkg::REG_FILL, 32'(DEPTH));
    b_op(RD, 36'h0_0000_0000);
    `CHK(o_port_b_data_bus, 36'h0_0000_1000)
    a_idle(3);
    `CHK(fr, 1'b1)
    pa.pulse(2'h2, 36'h0_0000_3000);
    `CHK(mtb, 1'b0)
    pa.pulse(2'h2, 36'h0_0000_3001);
    b_op(MB1, 36'h0_0000_0000);
    `CHK({mtb, o_port_b_data_bus}, {1'b1, 36'h0_0000_3000})
    b_op(MB2, 36'h0_0000_4000);
    `CHK(mta, 1'b0)
    pa.pulse(2'h3, 36'h0_0000_0000);
    `CHK({mta, o_mail2_data}, {1'b1, 36'h0_0000_4000})
    b_op(F2, 36'h0_0000_5000);
    b_op(4'h0, 36'h0_0000_6000);
    `CHK(f2_cnt, 1)
    `CHK({oe_n, o_fifo2_data}, {1'b1, 36'h0_0000_5000})
    conclude();
  end
endmodule
